/* hdl/fel_pkg.sv */
package fel_pkg;

    // ****************************************
    // Register indices (word index, byte address is four times)
    // ****************************************
    localparam logic [15:0] IDX_SET_DATE = 16'ha465;
    localparam logic [15:0] IDX_SET_TIME = 16'ha467;
    localparam logic [15:0] IDX_GET_DATE = 16'ha469;
    localparam logic [15:0] IDX_GET_TIME = 16'ha46b;
    localparam logic [15:0] IDX_SAMPLE_PERIOD = 16'ha46d;
    localparam logic [15:0] IDX_VALID_COUNT = 16'ha46e;
    localparam logic [15:0] IDX_INDEX_SELECT = 16'ha471;
    localparam logic [15:0] IDX_HEADER_REQUEST = 16'ha472;
    localparam logic [15:0] IDX_RECORD_SELECT = 16'ha473;
    localparam logic [15:0] IDX_WINDOW_BASE = 16'ha494;

    // ****************************************
    // Record and log layout
    // ****************************************
    localparam int PARAM_COUNT = 64;
    localparam int LAST_OFFSET = 68;
    localparam int REC_WORDS = LAST_OFFSET + 1;
    localparam int MAX_LOGS = 12;
    localparam logic [31:0] HEADER_REQ_VALUE = 32'h0000_0001;
    localparam logic [15:0] WORDS_PER_RECORD = 16'h0045;

    // ****************************************
    // Header word positions inside the window
    // ****************************************
    localparam int HDR_TIME_HI = 0;
    localparam int HDR_TIME_LO = 1;
    localparam int HDR_DATE_HI = 2;
    localparam int HDR_DATE_LO = 3;
    localparam int HDR_REC_COUNT = 4;
    localparam int HDR_WORDS = 5;
    localparam int HDR_PERIOD = 6;

    // ****************************************
    // Timing: sample period unit is 0.1 ms at 125 MHz
    // ****************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int PERIOD_UNIT_NS = 100000;
    localparam int PERIOD_UNIT_CYCLES = PERIOD_UNIT_NS / CLK_PERIOD_NS;
    localparam int SECOND_NS = 1000000000;
    localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [31:0] RST_DATE = 32'h0101_07e1;
    localparam logic [31:0] RST_TIME = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_POST = 2'b01,
        ST_COMMIT = 2'b10
    } fel_state_e;

endpackage

/* hdl/fel_reg_if.sv */
`timescale 1ns/1ns
// Register access strobes between bus slave and logger core
interface fel_reg_if;
    logic wr_en;
    logic rd_en;
    logic [15:0] idx;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport slave (output wr_en, output rd_en, output idx, output wdata, input rdata);
    modport core (input wr_en, input rd_en, input idx, input wdata, output rdata);
endinterface

/* hdl/fel_ahb_slave.sv */
`timescale 1ns/1ns
module fel_ahb_slave (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    fel_reg_if.slave bus
);
    import fel_pkg::*;

    logic wr_pend;
    logic rd_pend;
    logic [15:0] idx;
    wire take = i_hsel & i_htrans[1] & i_hready;
    // Addresses above the register space map to index zero, which decodes to nothing
    wire [15:0] addr_idx = (i_haddr[31:18] == 14'h0000) ? i_haddr[17:2] : 16'h0000;

    // ****************************************
    // Address phase capture
    // ****************************************
    // Reads take one wait state so a write just before them has landed
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            idx <= 16'h0000;
        end else begin
            wr_pend <= take & i_hwrite;
            rd_pend <= take & ~i_hwrite;
            if (take) begin
                idx <= addr_idx;
            end
        end
    end

    // Read data and ready from flops; response is always OKAY
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_hrdata <= 32'h0000_0000;
            o_hreadyout <= 1'b1;
        end else begin
            o_hreadyout <= ~(take & ~i_hwrite);
            if (rd_pend) begin
                o_hrdata <= bus.rdata;
            end
        end
    end

    assign bus.wr_en = wr_pend;
    assign bus.rd_en = rd_pend;
    assign bus.idx = idx;
    assign bus.wdata = i_hwdata;
endmodule

/* hdl/fel_rtc.sv */
`timescale 1ns/1ns
module fel_rtc #(
    parameter int SEC_CYCLES = fel_pkg::SECOND_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_set_date,
    input wire logic i_set_time,
    input wire logic i_capture,
    input wire logic [31:0] i_wdata,
    output logic [31:0] o_now_date,
    output logic [31:0] o_now_time,
    output logic [31:0] o_snap_date,
    output logic [31:0] o_snap_time
);
    import fel_pkg::*;

    logic [31:0] pend_date;
    logic [31:0] cyc;
    logic [7:0] mdays;
    wire sec_tick = (cyc == 32'(SEC_CYCLES - 1));
    wire [7:0] sec = o_now_time[23:16];
    wire [7:0] min = o_now_time[15:8];
    wire [7:0] hr = o_now_time[7:0];
    wire [7:0] day = o_now_date[31:24];
    wire [7:0] mon = o_now_date[23:16];
    wire [13:0] yr = o_now_date[13:0];
    wire roll_min = sec_tick & (sec == 8'h3b);
    wire roll_hr = roll_min & (min == 8'h3b);
    wire roll_day = roll_hr & (hr == 8'h17);
    wire roll_mon = roll_day & (day >= mdays);
    wire roll_yr = roll_mon & (mon >= 8'h0c);

    // Days in the current month, with a four-year leap rule
    always_comb begin
        case (mon)
            8'h02: mdays = (yr[1:0] == 2'b00) ? 8'h1d : 8'h1c;
            8'h04, 8'h06, 8'h09, 8'h0b: mdays = 8'h1e;
            default: mdays = 8'h1f;
        endcase
    end

    // ****************************************
    // Running clock, pending date and read snapshot
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cyc <= 32'h0000_0000;
            pend_date <= RST_DATE;
            o_now_date <= RST_DATE;
            o_now_time <= RST_TIME;
            o_snap_date <= RST_DATE;
            o_snap_time <= RST_TIME;
        end else begin
            cyc <= sec_tick ? 32'h0000_0000 : cyc + 32'h0000_0001;
            if (i_set_date) begin
                pend_date <= {i_wdata[31:16], 2'b00, i_wdata[13:0]};
            end
            if (i_set_time) begin
                // Date and time load together so neither rolls over alone
                o_now_date <= pend_date;
                o_now_time <= {8'h00, i_wdata[23:0]};
                cyc <= 32'h0000_0000;
            end else if (sec_tick) begin
                o_now_time[23:16] <= roll_min ? 8'h00 : sec + 8'h01;
                if (roll_min) o_now_time[15:8] <= roll_hr ? 8'h00 : min + 8'h01;
                if (roll_hr) o_now_time[7:0] <= roll_day ? 8'h00 : hr + 8'h01;
                if (roll_day) o_now_date[31:24] <= roll_mon ? 8'h01 : day + 8'h01;
                if (roll_mon) o_now_date[23:16] <= roll_yr ? 8'h01 : mon + 8'h01;
                if (roll_yr) o_now_date[13:0] <= yr + 14'h0001;
            end
            if (i_capture) begin
                o_snap_date <= {o_now_date[31:16], 2'b00, o_now_date[13:0]};
                o_snap_time <= o_now_time;
            end
        end
    end
endmodule

/* hdl/fel_logger.sv */
`timescale 1ns/1ns
module fel_logger
    import fel_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int POST_SAMPLES = 8,
    parameter logic [15:0] SAMPLE_PERIOD = 16'h0001,
    parameter int UNIT_CYCLES = fel_pkg::PERIOD_UNIT_CYCLES,
    parameter int SEC_CYCLES = fel_pkg::SECOND_CYCLES
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    input wire logic I_FAULT,
    input wire logic [fel_pkg::REC_WORDS*16-1:0] I_PARAM_RECORD,
    output logic O_LOG_BUSY
);
    import fel_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int RW = REC_WORDS * 16;

    // ****************************************
    // Bus slave and clock
    // ****************************************
    fel_reg_if regs ();
    logic [31:0] now_date;
    logic [31:0] now_time;
    // Get-date answers from the live clock, since its data loads on the snapshot edge
    logic [31:0] snap_time;

    fel_ahb_slave u_slave (
        .i_clk(I_SYS_CLK),
        .i_rst_n(I_RST_N),
        .i_hsel(I_HSEL),
        .i_haddr(I_HADDR),
        .i_htrans(I_HTRANS),
        .i_hwrite(I_HWRITE),
        .i_hwdata(I_HWDATA),
        .i_hready(I_HREADY),
        .o_hrdata(O_HRDATA),
        .o_hreadyout(O_HREADYOUT),
        .bus(regs.slave)
    );

    // Register write and read decode
    wire wr_set_date = regs.wr_en & (regs.idx == IDX_SET_DATE);
    wire wr_set_time = regs.wr_en & (regs.idx == IDX_SET_TIME);
    wire rd_get_date = regs.rd_en & (regs.idx == IDX_GET_DATE);
    wire wr_select = regs.wr_en & (regs.idx == IDX_INDEX_SELECT);
    wire wr_header = regs.wr_en & (regs.idx == IDX_HEADER_REQUEST) & (regs.wdata == HEADER_REQ_VALUE);
    wire wr_record = regs.wr_en & (regs.idx == IDX_RECORD_SELECT);

    fel_rtc #(
        .SEC_CYCLES(SEC_CYCLES)
    ) u_rtc (
        .i_clk(I_SYS_CLK),
        .i_rst_n(I_RST_N),
        .i_set_date(wr_set_date),
        .i_set_time(wr_set_time),
        .i_capture(rd_get_date),
        .i_wdata(regs.wdata),
        .o_now_date(now_date),
        .o_now_time(now_time),
        .o_snap_date(),
        .o_snap_time(snap_time)
    );

    // ****************************************
    // Fault pin synchroniser
    // ****************************************
    logic fault_meta;
    logic fault_sync;
    logic fault_prev;

    // Pin is asynchronous to the system clock; edge detect compares the second and third stages
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            fault_meta <= 1'b0;
            fault_sync <= 1'b0;
            fault_prev <= 1'b0;
        end else begin
            fault_meta <= I_FAULT;
            fault_sync <= fault_meta;
            fault_prev <= fault_sync;
        end
    end

    wire fault_rise = fault_sync & ~fault_prev;

    // ****************************************
    // Sample period timer
    // ****************************************
    logic [31:0] unit_cnt;
    logic [15:0] per_cnt;
    wire unit_tick = (unit_cnt == 32'(UNIT_CYCLES - 1));
    // A period of zero would stall sampling forever, so it is treated as one unit
    wire [15:0] per_last = (SAMPLE_PERIOD == 16'h0000) ? 16'h0000 : SAMPLE_PERIOD - 16'h0001;
    wire sample_tick = unit_tick & (per_cnt == per_last);

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            unit_cnt <= 32'h0000_0000;
            per_cnt <= 16'h0000;
        end else begin
            unit_cnt <= unit_tick ? 32'h0000_0000 : unit_cnt + 32'h0000_0001;
            if (sample_tick) begin
                per_cnt <= 16'h0000;
            end else if (unit_tick) begin
                per_cnt <= per_cnt + 16'h0001;
            end
        end
    end

    // ****************************************
    // RAM ring and fault sequencing
    // ****************************************
    logic [RW-1:0] ring [DEPTH];
    logic [AW-1:0] wptr;
    fel_state_e state;
    logic [15:0] post_left;
    logic [31:0] flt_date;
    logic [31:0] flt_time;

    // Ring keeps filling during post-fault collection, stops only on commit
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            wptr <= '0;
        end else if (sample_tick && state != ST_COMMIT) begin
            wptr <= wptr + AW'(1);
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (sample_tick && state != ST_COMMIT) begin
            ring[wptr] <= I_PARAM_RECORD;
        end
    end

    // Faults arriving during post collection or commit fold into the current log
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state <= ST_RUN;
            post_left <= 16'h0000;
            flt_date <= RST_DATE;
            flt_time <= RST_TIME;
        end else begin
            case (state)
                ST_RUN: begin
                    if (fault_rise) begin
                        state <= ST_POST;
                        post_left <= 16'(POST_SAMPLES);
                        flt_date <= now_date;
                        flt_time <= now_time;
                    end
                end
                ST_POST: begin
                    if (sample_tick) begin
                        post_left <= post_left - 16'h0001;
                        if (post_left <= 16'h0001) begin
                            state <= ST_COMMIT;
                        end
                    end
                end
                ST_COMMIT: begin
                    state <= ST_RUN;
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    // ****************************************
    // Stored log slots
    // ****************************************
    logic [RW-1:0] store [MAX_LOGS][DEPTH];
    logic [31:0] store_date [MAX_LOGS];
    logic [31:0] store_time [MAX_LOGS];
    logic [3:0] next_slot;
    logic [3:0] valid_count;
    wire commit = (state == ST_COMMIT);

    // Copy oldest-first so record zero is the earliest sample
    for (genvar k = 0; k < DEPTH; k++) begin : g_copy
        always_ff @(posedge I_SYS_CLK) begin
            if (commit) begin
                store[next_slot][k] <= ring[wptr + AW'(k)];
            end
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (commit) begin
            store_date[next_slot] <= flt_date;
            store_time[next_slot] <= flt_time;
        end
    end

    // Slot pointer wraps at twelve, overwriting the oldest once full
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            next_slot <= 4'h0;
            valid_count <= 4'h0;
        end else if (commit) begin
            next_slot <= (next_slot == 4'(MAX_LOGS - 1)) ? 4'h0 : next_slot + 4'h1;
            if (valid_count != 4'(MAX_LOGS)) begin
                valid_count <= valid_count + 4'h1;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_LOG_BUSY <= 1'b0;
        end else begin
            O_LOG_BUSY <= (state != ST_RUN);
        end
    end

    // ****************************************
    // Log selection and read window
    // ****************************************
    logic [15:0] sel_index;
    logic [15:0] win [REC_WORDS];

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            sel_index <= 16'h0000;
        end else if (wr_select) begin
            sel_index <= regs.wdata[15:0];
        end
    end

    // Age order: once full, the oldest log sits at the next slot to be written
    wire [4:0] phys_sum = (valid_count == 4'(MAX_LOGS)) ? 5'(next_slot) + 5'(sel_index[3:0]) : 5'(sel_index[3:0]);
    wire [3:0] phys_slot = (phys_sum >= 5'(MAX_LOGS)) ? 4'(phys_sum - 5'(MAX_LOGS)) : phys_sum[3:0];
    wire sel_ok = (sel_index < 16'(valid_count));
    wire rec_ok = sel_ok & (regs.wdata < 32'(DEPTH));
    wire [AW-1:0] rec_sel = regs.wdata[AW-1:0];
    wire [31:0] hdr_date = store_date[phys_slot];
    wire [31:0] hdr_time = store_time[phys_slot];

    // Header words; a missing log reads as zeros
    logic [15:0] hdr_word [REC_WORDS];
    always_comb begin
        for (int w = 0; w < REC_WORDS; w++) begin
            hdr_word[w] = 16'h0000;
        end
        if (sel_ok) begin
            hdr_word[HDR_TIME_HI] = hdr_time[31:16];
            hdr_word[HDR_TIME_LO] = hdr_time[15:0];
            hdr_word[HDR_DATE_HI] = hdr_date[31:16];
            hdr_word[HDR_DATE_LO] = hdr_date[15:0];
            hdr_word[HDR_REC_COUNT] = 16'(DEPTH);
            hdr_word[HDR_WORDS] = WORDS_PER_RECORD;
            hdr_word[HDR_PERIOD] = SAMPLE_PERIOD;
        end
    end

    for (genvar w = 0; w < REC_WORDS; w++) begin : g_win
        always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
            if (!I_RST_N) begin
                win[w] <= 16'h0000;
            end else if (wr_header) begin
                win[w] <= hdr_word[w];
            end else if (wr_record) begin
                win[w] <= rec_ok ? store[phys_slot][rec_sel][w*16 +: 16] : 16'h0000;
            end
        end
    end

    // ****************************************
    // Read mux
    // ****************************************
    wire [15:0] win_off = regs.idx - IDX_WINDOW_BASE;
    wire in_win = (regs.idx >= IDX_WINDOW_BASE) && (win_off < 16'(REC_WORDS));
    wire [6:0] win_sel = win_off[6:0];

    always_comb begin
        case (regs.idx)
            IDX_GET_DATE: regs.rdata = now_date;
            IDX_GET_TIME: regs.rdata = snap_time;
            IDX_SAMPLE_PERIOD: regs.rdata = {16'h0000, SAMPLE_PERIOD};
            IDX_VALID_COUNT: regs.rdata = {28'h000_0000, valid_count};
            IDX_INDEX_SELECT: regs.rdata = {16'h0000, sel_index};
            default: regs.rdata = in_win ? {16'h0000, win[win_sel]} : 32'h0000_0000;
        endcase
    end

    // Only OKAY responses; transfer size is not checked
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_HRESP <= 1'b0;
        end else begin
            O_HRESP <= 1'b0;
        end
    end

    wire unused_ok = &{1'b0, I_HSIZE};
endmodule

/* sim/fel_logger_assertions.sv */
`timescale 1ns/1ns
// Watches the bus answer and the logging busy flag at the top ports
module fel_logger_checker (
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    input wire logic I_HSEL,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic I_HREADY,
    input wire logic I_FAULT,
    input wire logic [31:0] O_HRDATA,
    input wire logic O_HREADYOUT,
    input wire logic O_HRESP,
    input wire logic O_LOG_BUSY
);
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_RST_N);
    // Address phase accepted by the slave
    wire taken = I_HSEL & I_HTRANS[1] & I_HREADY;
    resp_okay_a:
        assert property (O_HRESP == 1'b0) else $error("response not OKAY");
    read_wait_a:
        assert property (taken && !I_HWRITE |=> !O_HREADYOUT ##1 O_HREADYOUT) else $error("read wait state wrong");
    write_nowait_a:
        assert property (taken && I_HWRITE |=> O_HREADYOUT) else $error("write stalled");
    stall_cause_a:
        assert property (!O_HREADYOUT |-> $past(taken && !I_HWRITE)) else $error("stall without read");
    rdata_hold_a:
        assert property (O_HREADYOUT && $past(O_HREADYOUT) |-> $stable(O_HRDATA)) else $error("read data moved");
    busy_start_a:
        assert property ($rose(I_FAULT) && !O_LOG_BUSY |-> ##[2:5] O_LOG_BUSY) else $error("fault not taken");
    busy_cause_a:
        assert property ($rose(O_LOG_BUSY) |-> $past(I_FAULT, 3) || $past(I_FAULT, 4) || $past(I_FAULT, 5))
            else $error("busy without fault");
    post_hold_a:
        assert property ($rose(O_LOG_BUSY) |-> O_LOG_BUSY [*8]) else $error("post samples cut short");
    busy_end_a:
        assert property ($rose(O_LOG_BUSY) |-> ##[1:100] !O_LOG_BUSY) else $error("log never frozen");
endmodule

bind fel_logger fel_logger_checker i_chk (
    .I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_HSEL(I_HSEL), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE),
    .I_HREADY(I_HREADY), .I_FAULT(I_FAULT), .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT),
    .O_HRESP(O_HRESP), .O_LOG_BUSY(O_LOG_BUSY)
);

/* sim/fel_host_model.sv */
`timescale 1ns/1ns
// Host on the register bus: single word transfers only
module fel_host_model
    import fel_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_hready,
    input wire logic [31:0] i_hrdata,
    output logic [31:0] o_haddr,
    output logic [1:0] o_htrans,
    output logic o_hwrite,
    output logic [31:0] o_hwdata
);
    // Idle bus at time zero; select stays high, IDLE keeps the slave quiet
    initial begin
        o_haddr = 32'h0000_0000;
        o_htrans = 2'h0;
        o_hwrite = 1'b0;
        o_hwdata = 32'h0000_0000;
    end
    // Write: address held until ready, then data held until ready
    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        o_htrans <= 2'h2;
        o_haddr <= {14'h0000, idx, 2'h0};
        o_hwrite <= 1'b1;
        do @(posedge i_clk); while (i_hready !== 1'b1);
        o_htrans <= 2'h0;
        o_hwdata <= d;
        do @(posedge i_clk); while (i_hready !== 1'b1);
    endtask
    // Read: data taken at the edge where ready returns
    task automatic rd(input logic [15:0] idx, output logic [31:0] d);
        o_htrans <= 2'h2;
        o_haddr <= {14'h0000, idx, 2'h0};
        o_hwrite <= 1'b0;
        do @(posedge i_clk); while (i_hready !== 1'b1);
        o_htrans <= 2'h0;
        do @(posedge i_clk); while (i_hready !== 1'b1);
        d = i_hrdata;
    endtask
    // Date always goes first and is always followed by its time
    task automatic set_clock(input logic [31:0] date, input logic [31:0] tod);
        wr(IDX_SET_DATE, date);
        wr(IDX_SET_TIME, tod);
    endtask
    // Count is read first; a log is chosen only when one exists
    task automatic select_log(input logic [15:0] sel, output logic [31:0] cnt);
        rd(IDX_VALID_COUNT, cnt);
        if (cnt != 32'h0000_0000) begin
            wr(IDX_INDEX_SELECT, {16'h0000, sel});
        end
    endtask
endmodule

/* sim/tb.sv */
`timescale 1ns/1ns
module tb;
    import fel_pkg::*;
    logic clk, rst_n, fault, hready, hresp, busy;
    logic [31:0] haddr, hwdata, hrdata, v, w;
    logic [1:0] htrans;
    logic hwrite;
    logic [REC_WORDS*16-1:0] rec;
    logic [15:0] hdr [7];
    int num_errors = 0;
    int checks_done = 0;

    fel_logger #(.UNIT_CYCLES(2), .SEC_CYCLES(50)) i_dut (
        .I_SYS_CLK(clk), .I_RST_N(rst_n), .I_HSEL(1'b1), .I_HADDR(haddr), .I_HTRANS(htrans),
        .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
        .O_HREADYOUT(hready), .O_HRESP(hresp), .I_FAULT(fault), .I_PARAM_RECORD(rec), .O_LOG_BUSY(busy)
    );
    fel_host_model i_host (.i_clk(clk), .i_hready(hready), .i_hrdata(hrdata), .o_haddr(haddr),
        .o_htrans(htrans), .o_hwrite(hwrite), .o_hwdata(hwdata));

    // **********
    // Common tasks
    // **********
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Choose a log, ask for its header and copy the seven header words
    task automatic hdr_load(input logic [15:0] sel);
        i_host.select_log(sel, v);
        i_host.wr(IDX_HEADER_REQUEST, 32'h0000_0001);
        for (int i = 0; i < 7; i++) begin
            i_host.rd(IDX_WINDOW_BASE + 16'(i), v);
            hdr[i] = v[15:0];
        end
    endtask

    // **********
    // Scenarios
    // **********
    task t_regs;
        i_host.rd(IDX_SAMPLE_PERIOD, v);
        check(v, 32'h0000_0001);
        i_host.wr(IDX_SAMPLE_PERIOD, 32'h0000_0007);
        i_host.rd(IDX_SAMPLE_PERIOD, v);
        check(v, 32'h0000_0001);
        i_host.rd(IDX_VALID_COUNT, v);
        check(v, 32'h0000_0000);
        i_host.rd(16'h0004, v);
        check(v, 32'h0000_0000);
        check({31'h0000_0000, hresp}, 32'h0000_0000);
        $display("t_regs done");
    endtask
    // Lone date stays pending; snapshot time does not run on after the date read
    task t_clock;
        i_host.wr(IDX_SET_DATE, 32'h0202_07e2);
        i_host.rd(IDX_GET_DATE, v);
        check(v, 32'h0101_07e1);
        i_host.set_clock(32'h1503_c7e1, 32'hff10_2003);
        i_host.rd(IDX_GET_DATE, v);
        check(v, 32'h1503_07e1);
        repeat (120) @(posedge clk);
        i_host.rd(IDX_GET_TIME, w);
        check({8'h00, w[31:24], w[15:0]}, 32'h0000_2003);
        check({31'h0000_0000, w[23:16] < 8'h12}, 32'h0000_0001);
        $display("t_clock done");
    endtask
    // Thirteen faults: count climbs to twelve and then stays there
    task t_faults;
        int k;
        for (int n = 1; n <= 13; n++) begin
            fault <= 1'b1;
            repeat (4) @(posedge clk);
            fault <= 1'b0;
            k = 0;
            while (busy !== 1'b1 && k < 20) begin
                @(posedge clk);
                k++;
            end
            check({31'h0000_0000, busy}, 32'h0000_0001);
            while (busy !== 1'b0 && k < 300) begin
                @(posedge clk);
                k++;
            end
            repeat (60) @(posedge clk);
            i_host.rd(IDX_VALID_COUNT, v);
            check(v, 32'((n > 12) ? 12 : n));
        end
        $display("t_faults done");
    endtask
    // Header layout, age order and the empty slot past the newest
    task t_header;
        hdr_load(16'h000b);
        w = {hdr[0], hdr[1]};
        hdr_load(16'h0000);
        check({hdr[2], hdr[3]}, 32'h1503_07e1);
        check({hdr[4], hdr[5]}, 32'h0010_0045);
        check({16'h0000, hdr[6]}, 32'h0000_0001);
        check({24'h00_0000, hdr[0][15:8]}, 32'h0000_0000);
        check({31'h0000_0000, {hdr[0], hdr[1]} < w}, 32'h0000_0001);
        hdr_load(16'h000c);
        check({16'h0000, hdr[4]}, 32'h0000_0000);
        $display("t_header done");
    endtask
    // Stored record words sit at their fixed offsets; a record past the ring reads zero
    task t_record;
        hdr_load(16'h0000);
        i_host.wr(IDX_RECORD_SELECT, 32'h0000_0003);
        i_host.rd(IDX_WINDOW_BASE + 16'h0005, v);
        check(v & 32'h0000_ffff, 32'h0000_0a05);
        i_host.rd(IDX_WINDOW_BASE + 16'h0044, v);
        check(v & 32'h0000_ffff, 32'h0000_0a44);
        i_host.wr(IDX_RECORD_SELECT, 32'h0000_0010);
        i_host.rd(IDX_WINDOW_BASE, v);
        check(v, 32'h0000_0000);
        $display("t_record done");
    endtask

    // Free running clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Reset, then the scenarios in turn
    initial begin
        rst_n = 1'b0;
        fault = 1'b0;
        for (int i = 0; i < REC_WORDS; i++) begin
            rec[i*16 +: 16] = 16'h0a00 + 16'(i);
        end
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_clock();
        t_faults();
        t_header();
        t_record();
        test_done();
    end
    // Watchdog well past the roughly 1400 cycles the run needs
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        test_done();
    end
endmodule
